// file: logic/sacr_device.sv
// Converter end: convert start, busy, result register and output drivers.
`timescale 1ns/1ps
`default_nettype none
`include "sacr_defines.svh"
module sacr_device (
   input  wire logic                   i_clk_sys,
   input  wire logic                   i_rstn,
   sacr_link_if.dev                    link,
   input  wire logic                   i_byte_mode,
   input  wire sacr_pkg::sacr_word_t   i_sample,
   output logic                        o_sampling,
   output logic                        o_conv_busy
);
   localparam int PULSE_CYC = `SACR_CONV_PULSE_MIN_CYC;
   localparam int CONV_CYC  = `SACR_CONV_TIME_CYC;

   // Timing at the 200 MHz system clock, counted in rising edges.
   //  - Both control inputs must be sampled low on eight edges in a row before
   //    a conversion starts; a shorter pulse leaves the converter tracking.
   //  - The start edge freezes the sample and drops busy; busy stays low for the
   //    full conversion count and rises on the edge that loads the result.
   //  - The bus data register is loaded from the same next value as the result,
   //    so the new word is already on the pins when busy is seen high.
   //  - The low-time counter keeps running during a conversion. Inputs still
   //    low when busy rises therefore restart at once on a stale sample; the
   //    host end avoids that by releasing both lines early.
   //  - Output enables are combinational from the pins, so release and access
   //    follow the select and convert lines without a clock of delay.
   //  - The previous result stays readable through the whole conversion here,
   //    longer than a host may rely on; a portable host stops reading early.
   //  - Reset leaves the converter tracking with a zero result and busy high,
   //    so a read before any conversion returns zero rather than an unknown.
   //  - In byte mode the chosen half sits in the low lane and the upper lane
   //    reads zero; byte select is taken on every edge, so a toggle within one
   //    conversion cycle reaches the pins one edge later.

   sacr_pkg::sacr_dev_state_t state;
   sacr_pkg::sacr_dev_state_t next_state;
   logic [3:0]                low_cnt;
   logic [3:0]                next_low_cnt;
   logic [11:0]               conv_cnt;
   logic [11:0]               next_conv_cnt;
   sacr_pkg::sacr_word_t      held;
   sacr_pkg::sacr_word_t      next_held;
   sacr_pkg::sacr_word_t      result;
   sacr_pkg::sacr_word_t      next_result;
   logic [15:0]               bus_q;
   logic [15:0]               next_bus_q;
   logic                      both_low;
   logic                      start;
   logic                      drive;
   logic                      conv_end;

   // Byte lane selection: low picks the upper half, high the lower half.
   function automatic logic [15:0] sacr_lane(input sacr_pkg::sacr_word_t w, input logic sel, input logic bytes);
      logic [15:0] r;
      r = w;
      if (bytes) begin
         r = sel ? {8'h00, w[7:0]} : {8'h00, w[15:8]};
      end
      return r;
   endfunction

   // Saturating increment for the four-bit low-time counter.
   function automatic logic [3:0] sacr_sat_inc(input logic [3:0] v);
      logic [3:0] r;
      r = v;
      if (v != 4'hF) begin
         r = v + 4'h1;
      end
      return r;
   endfunction

   // Level-triggered AND of two active-low inputs, so either may fall last.
   assign both_low = !link.cs_n && !link.rd_conv;
   // A start is only seen in tracking, so requests during busy are dropped.
   assign start = (state == sacr_pkg::SACR_DEV_TRACK) && both_low
                  && (low_cnt >= 4'(PULSE_CYC - 1));

   // Start qualifier: counts edges with both inputs low and saturates, so a
   // pulse held far past the minimum never wraps back below the threshold.
   always_comb begin
      next_low_cnt = 4'h0;
      if (both_low) begin
         next_low_cnt = sacr_sat_inc(low_cnt);
      end
   end

   // Register of the start qualifier.
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         low_cnt <= 4'h0;
      end else begin
         low_cnt <= next_low_cnt;
      end
   end

   // End of conversion: the last counted edge of a conversion.
   assign conv_end = (state == sacr_pkg::SACR_DEV_CONV) && (conv_cnt == 12'h000);

   // Conversion machine: tracking until a qualified start, then a fixed count.
   // Requests seen while converting are not decoded, so they cannot disturb it.
   always_comb begin
      next_state    = state;
      next_conv_cnt = conv_cnt;
      case (state)
         sacr_pkg::SACR_DEV_TRACK: begin
            if (start) begin
               next_state    = sacr_pkg::SACR_DEV_CONV;
               next_conv_cnt = 12'(CONV_CYC - 1);
            end
         end
         sacr_pkg::SACR_DEV_CONV: begin
            // Inputs held low keep counting; at the busy rise they restart at once.
            if (conv_end) begin
               next_state = sacr_pkg::SACR_DEV_TRACK;
            end else begin
               next_conv_cnt = conv_cnt - 12'h001;
            end
         end
         default: begin
            next_state    = sacr_pkg::SACR_DEV_TRACK;
            next_conv_cnt = 12'h000;
         end
      endcase
   end

   // Registers of the conversion machine.
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         state    <= sacr_pkg::SACR_DEV_TRACK;
         conv_cnt <= 12'h000;
      end else begin
         state    <= next_state;
         conv_cnt <= next_conv_cnt;
      end
   end

   // Sample and result registers. The sample is frozen on the start edge, the
   // hold instant; the result only moves on the end edge, so repeated reads
   // between two conversions return the same word.
   always_comb begin
      next_held   = held;
      next_result = result;
      if (start) begin
         next_held = i_sample;
      end
      if (conv_end) begin
         next_result = held;
      end
   end

   // Registers of the sample and the result.
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         held   <= `SACR_RESULT_RST;
         result <= `SACR_RESULT_RST;
      end else begin
         held   <= next_held;
         result <= next_result;
      end
   end

   // Drivers on only with select low and convert high, also when select is tied low.
   assign drive = !link.cs_n && link.rd_conv;

   // Bus data register, loaded from the next result so that it moves on the
   // same edge as the result and busy. A copy of the current result would lag
   // by one edge and show the old word just when a host latches on busy rise.
   always_comb begin
      next_bus_q = sacr_lane(next_result, link.byte_sel, i_byte_mode);
   end

   // Register of the bus data.
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         bus_q <= `SACR_RESULT_RST;
      end else begin
         bus_q <= next_bus_q;
      end
   end

   // Pin and status outputs; busy and the status flags come from the state register.
   assign link.data_out  = bus_q;
   assign link.data_oe_n = {16{!drive}};
   assign link.busy_n    = (state != sacr_pkg::SACR_DEV_CONV);
   assign o_sampling     = (state == sacr_pkg::SACR_DEV_TRACK);
   assign o_conv_busy    = (state == sacr_pkg::SACR_DEV_CONV);
endmodule
`default_nettype wire

// file: logic/sacr_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module sacr_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic             i_clk_sys,
   input  wire logic             i_rstn,
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic      [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW-1:0]    next_wr_ptr;
   logic [AW-1:0]    next_rd_ptr;
   logic [AW:0]      next_count;
   logic             push;
   logic             pop;

   // Full and empty come straight from the occupancy count.
   assign o_in_ready  = (count != DEPTH[AW:0]);
   assign o_out_valid = (count != '0);
   assign o_out_data  = mem[rd_ptr];
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;

   // Pointer and count update; pointers wrap because depth is a power of two.
   always_comb begin
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
      next_count  = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   // Registers for the pointers and count.
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   // Storage has no reset; only written slots are ever read.
   always_ff @(posedge i_clk_sys) begin
      if (push) begin
         mem[wr_ptr] <= i_in_data;
      end
   end
endmodule
`default_nettype wire

// file: logic/sacr_host.sv
// Host end: issues convert pulses, reads results and buffers them in a FIFO.
`timescale 1ns/1ps
`default_nettype none
`include "sacr_defines.svh"
module sacr_host (
   input  wire logic                   i_clk_sys,
   input  wire logic                   i_rstn,
   sacr_link_if.host                   link,
   input  wire logic                   i_start,
   input  wire logic                   i_byte_mode,
   output logic                        o_res_valid,
   input  wire logic                   i_res_ready,
   output sacr_pkg::sacr_word_t        o_res_data
);
   localparam int PULSE_CYC = `SACR_CONV_PULSE_MIN_CYC + 2;
   localparam int SETUP_CYC = `SACR_SETUP_CYC;
   localparam int GAP_CYC   = `SACR_BETWEEN_CYC;

   sacr_pkg::sacr_host_state_t state;
   sacr_pkg::sacr_host_state_t next_state;
   logic [11:0]                cnt;
   logic [11:0]                next_cnt;
   logic                       cs_n;
   logic                       next_cs_n;
   logic                       rd_conv;
   logic                       next_rd_conv;
   logic                       byte_sel;
   logic                       next_byte_sel;
   sacr_pkg::sacr_word_t       word;
   sacr_pkg::sacr_word_t       next_word;
   logic                       busy_q;
   logic                       fifo_ready;

   // Convert, wait for busy rise, read the word or both bytes, push it.
   always_comb begin
      next_state    = state;
      next_cnt      = (cnt != 12'h000) ? cnt - 12'h001 : cnt;
      next_cs_n     = cs_n;
      next_rd_conv  = rd_conv;
      next_byte_sel = byte_sel;
      next_word     = word;
      case (state)
         sacr_pkg::SACR_HOST_IDLE: begin
            if (i_start && link.busy_n && fifo_ready) begin
               next_rd_conv = 1'b0;
               next_cnt     = 12'(SETUP_CYC);
               next_state   = sacr_pkg::SACR_HOST_SETUP;
            end
         end
         sacr_pkg::SACR_HOST_SETUP: begin
            if (cnt == 12'h000) begin
               next_cs_n  = 1'b0;
               next_cnt   = 12'(PULSE_CYC);
               next_state = sacr_pkg::SACR_HOST_PULSE;
            end
         end
         sacr_pkg::SACR_HOST_PULSE: begin
            if (cnt == 12'h000) begin
               next_cs_n    = 1'b1;
               next_rd_conv = 1'b1;
               next_state   = sacr_pkg::SACR_HOST_WAIT;
            end
         end
         sacr_pkg::SACR_HOST_WAIT: begin
            // No read during the conversion; busy rise is the strobe.
            if (!busy_q && link.busy_n) begin
               next_cs_n     = 1'b0;
               next_byte_sel = 1'b0;
               next_cnt      = 12'h003;
               next_state    = sacr_pkg::SACR_HOST_READ;
            end
         end
         sacr_pkg::SACR_HOST_READ: begin
            if (cnt == 12'h000) begin
               next_word = i_byte_mode ? {link.data_out[7:0], 8'h00} : link.data_out;
               if (i_byte_mode) begin
                  next_byte_sel = 1'b1;
                  next_cnt      = 12'h003;
                  next_state    = sacr_pkg::SACR_HOST_READL;
               end else begin
                  next_state = sacr_pkg::SACR_HOST_PUSH;
               end
            end
         end
         sacr_pkg::SACR_HOST_READL: begin
            if (cnt == 12'h000) begin
               next_word  = {word[15:8], link.data_out[7:0]};
               next_state = sacr_pkg::SACR_HOST_PUSH;
            end
         end
         sacr_pkg::SACR_HOST_PUSH: begin
            next_cs_n = 1'b1;
            if (fifo_ready) begin
               next_cnt   = 12'(GAP_CYC - 1);
               next_state = sacr_pkg::SACR_HOST_GAP;
            end
         end
         sacr_pkg::SACR_HOST_GAP: begin
            if (cnt == 12'h000) begin
               next_state = sacr_pkg::SACR_HOST_IDLE;
            end
         end
         default: begin
            next_state = sacr_pkg::SACR_HOST_IDLE;
         end
      endcase
   end

   // Idle pins: select and convert high, so the bus is released.
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         state    <= sacr_pkg::SACR_HOST_IDLE;
         cnt      <= 12'h000;
         cs_n     <= 1'b1;
         rd_conv  <= 1'b1;
         byte_sel <= 1'b0;
         word     <= 16'h0000;
         busy_q   <= 1'b1;
      end else begin
         state    <= next_state;
         cnt      <= next_cnt;
         cs_n     <= next_cs_n;
         rd_conv  <= next_rd_conv;
         byte_sel <= next_byte_sel;
         word     <= next_word;
         busy_q   <= link.busy_n;
      end
   end

   assign link.cs_n     = cs_n;
   assign link.rd_conv  = rd_conv;
   assign link.byte_sel = byte_sel;

   // Results queue here; a stalled consumer blocks new conversions.
   sacr_fifo #(
      .WIDTH (`SACR_DATA_W),
      .DEPTH (`SACR_FIFO_DEPTH)
   ) u_fifo (
      .i_clk_sys   (i_clk_sys),
      .i_rstn      (i_rstn),
      .i_in_valid  (state == sacr_pkg::SACR_HOST_PUSH),
      .o_in_ready  (fifo_ready),
      .i_in_data   (word),
      .o_out_valid (o_res_valid),
      .i_out_ready (i_res_ready),
      .o_out_data  (o_res_data)
   );
endmodule
`default_nettype wire

// file: pkg/sacr_defines.svh
// Timing counts, widths and reset values for the converter control block.
`ifndef SACR_DEFINES_SVH
`define SACR_DEFINES_SVH
`define SACR_CLK_MHZ          200
`define SACR_DATA_W           16
`define SACR_BYTE_W           8
`define SACR_FIFO_DEPTH       8
`define SACR_CONV_PULSE_MIN_NS 40
`define SACR_CONV_PULSE_MAX_NS 7000
`define SACR_SETUP_NS         10
`define SACR_BETWEEN_US       10
`define SACR_CONV_TIME_NS     8000
`define SACR_PREV_VALID_US    7
`define SACR_CONV_PULSE_MIN_CYC ((`SACR_CONV_PULSE_MIN_NS * `SACR_CLK_MHZ + 999) / 1000)
`define SACR_CONV_PULSE_MAX_CYC ((`SACR_CONV_PULSE_MAX_NS * `SACR_CLK_MHZ) / 1000)
`define SACR_SETUP_CYC        ((`SACR_SETUP_NS * `SACR_CLK_MHZ + 999) / 1000)
`define SACR_BETWEEN_CYC      (`SACR_BETWEEN_US * `SACR_CLK_MHZ)
`define SACR_CONV_TIME_CYC    ((`SACR_CONV_TIME_NS * `SACR_CLK_MHZ) / 1000)
`define SACR_PREV_VALID_CYC   (`SACR_PREV_VALID_US * `SACR_CLK_MHZ)
`define SACR_RESULT_RST       16'h0000
`endif

// file: pkg/sacr_link_if.sv
// Pin-level link between the converter end and the host end.
`timescale 1ns/1ps
`default_nettype none
interface sacr_link_if;
   logic        cs_n;
   logic        rd_conv;
   logic        byte_sel;
   logic        busy_n;
   logic [15:0] data_out;
   logic [15:0] data_oe_n;
   modport dev  (input cs_n, input rd_conv, input byte_sel, output busy_n, output data_out, output data_oe_n);
   modport host (output cs_n, output rd_conv, output byte_sel, input busy_n, input data_out, input data_oe_n);
endinterface
`default_nettype wire

// file: pkg/sacr_pkg.sv
// Types shared by the converter control ends.
`default_nettype none
package sacr_pkg;
   typedef logic [15:0] sacr_word_t;
   typedef enum logic [1:0] {
      SACR_DEV_TRACK = 2'b00,
      SACR_DEV_CONV  = 2'b01
   } sacr_dev_state_t;
   typedef enum logic [2:0] {
      SACR_HOST_IDLE  = 3'b000,
      SACR_HOST_SETUP = 3'b001,
      SACR_HOST_PULSE = 3'b010,
      SACR_HOST_WAIT  = 3'b011,
      SACR_HOST_READ  = 3'b100,
      SACR_HOST_READL = 3'b101,
      SACR_HOST_PUSH  = 3'b110,
      SACR_HOST_GAP   = 3'b111
   } sacr_host_state_t;
endpackage
`default_nettype wire

// file: testbench/sacr_link_chk.sv
// Checker on the pin-level link between the converter end and the host end.
`timescale 1ns/1ps
`default_nettype none
module sacr_link_chk (
   input wire logic        i_clk_sys,
   input wire logic        i_rstn,
   input wire logic        cs_n,
   input wire logic        rd_conv,
   input wire logic        byte_sel,
   input wire logic        busy_n,
   input wire logic [15:0] data_out,
   input wire logic [15:0] data_oe_n
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rstn);
   logic [11:0] low_cnt;
   logic [11:0] busy_cnt;
   // Counters saturate, so a line stuck for long cannot wrap back into range.
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         low_cnt  <= 12'h000;
         busy_cnt <= 12'h000;
      end else begin
         low_cnt  <= (cs_n | rd_conv) ? 12'h000 : low_cnt + {11'h000, low_cnt != 12'hFFF};
         busy_cnt <= busy_n ? 12'h000 : busy_cnt + {11'h000, busy_cnt != 12'hFFF};
      end
   end
   // A convert request held for the full pulse, and the busy answer to it.
   sequence s_conv_req;
      (!cs_n && !rd_conv && busy_n) [*8];
   endsequence
   sequence s_busy_start;
      ##[1:2] !busy_n;
   endsequence
   a_select_high_float: assert property (cs_n |-> data_oe_n == 16'hFFFF)
      else $error("bus driven while deselected");
   a_convert_bus_float: assert property (!rd_conv |-> data_oe_n == 16'hFFFF)
      else $error("bus driven in convert mode");
   a_read_drives_bus: assert property (!cs_n && rd_conv |-> data_oe_n == 16'h0000)
      else $error("bus not driven in read mode");
   a_start_sets_busy: assert property (s_conv_req |-> s_busy_start)
      else $error("busy did not fall after convert pulse");
   a_start_needs_pulse: assert property ($fell(busy_n) |-> low_cnt >= 12'h008)
      else $error("conversion started on a short pulse");
   a_busy_length: assert property ($rose(busy_n) |-> busy_cnt >= 12'h63F && busy_cnt <= 12'h641)
      else $error("busy low time wrong");
   a_busy_stays_low: assert property (!busy_n && busy_cnt < 12'h63E |=> !busy_n)
      else $error("conversion ended early");
   a_restart_on_low: assert property ($rose(busy_n) && !cs_n && !rd_conv |-> ##[1:3] !busy_n)
      else $error("no restart with inputs low");
   a_data_holds: assert property (!busy_n && $past(byte_sel) == $past(byte_sel, 2) |-> $stable(data_out))
      else $error("result changed during conversion");
   a_host_releases: assert property ($rose(busy_n) |-> cs_n || rd_conv)
      else $error("convert inputs still low at busy rise");
   a_select_after_convert: assert property ($fell(cs_n) && !rd_conv |-> $past(rd_conv, 2) == 1'b0)
      else $error("select fell without convert setup");
endmodule
`default_nettype wire

// file: testbench/sar_adc_convert_read_control_test.sv
// Bench: host and converter ends face each other; a second converter is driven by hand.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_convert_read_control_test;
   logic                 i_clk_sys   = 1'b0;
   logic                 i_rstn      = 1'b0;
   logic                 start       = 1'b0;
   logic                 byte_mode   = 1'b0;
   logic                 byte_mode_b = 1'b0;
   logic                 res_ready   = 1'b0;
   logic                 res_valid;
   logic                 sampling_b;
   logic                 conv_busy_b;
   sacr_pkg::sacr_word_t res_data;
   sacr_pkg::sacr_word_t sample      = 16'h0000;
   sacr_pkg::sacr_word_t sample_b    = 16'h0000;
   int                   fail_count  = 0;
   int                   n_compared  = 0;
   int                   low_b       = 0;
   sacr_link_if link ();
   sacr_link_if link_b ();
   sacr_device u_sacr_device (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .link(link), .i_byte_mode(byte_mode),
      .i_sample(sample), .o_sampling(), .o_conv_busy());
   sacr_host u_sacr_host (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .link(link), .i_start(start),
      .i_byte_mode(byte_mode), .o_res_valid(res_valid), .i_res_ready(res_ready), .o_res_data(res_data));
   sacr_device u_sacr_device_b (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .link(link_b), .i_byte_mode(byte_mode_b),
      .i_sample(sample_b), .o_sampling(sampling_b), .o_conv_busy(conv_busy_b));
   sacr_link_chk u_sacr_link_chk (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .cs_n(link.cs_n),
      .rd_conv(link.rd_conv), .byte_sel(link.byte_sel), .busy_n(link.busy_n), .data_out(link.data_out),
      .data_oe_n(link.data_oe_n));
   // Clock, and a count of busy-low edges on the hand-driven converter.
   always #2.5 i_clk_sys = ~i_clk_sys;
   always @(posedge i_clk_sys) low_b <= link_b.busy_n ? 0 : low_b + 1;
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cycles(input int n);
      repeat (n) @(negedge i_clk_sys);
   endtask
   task automatic pins(input logic cs, input logic rc, input logic bs);
      link_b.cs_n = cs;
      link_b.rd_conv = rc;
      link_b.byte_sel = bs;
   endtask
   // Bounded wait, so a converter that never answers cannot hang the run.
   task automatic wait_busy(input bit on_b, input logic lvl, input int lim, output logic hit);
      while (((on_b ? link_b.busy_n : link.busy_n) !== lvl) && lim > 0) begin
         @(negedge i_clk_sys);
         lim--;
      end
      hit = (lim > 0);
   endtask
   // Eight results fill the FIFO with the reader stalled; the ninth start is held off.
   task automatic t_fill_drain();
      sacr_pkg::sacr_word_t tbl [9] = '{16'h7FFF, 16'h0000, 16'hFFFF, 16'h8000, 16'h1234,
                                        16'hA5C3, 16'h0001, 16'hFEDC, 16'h5A5A};
      logic hit;
      int   n = 0;
      start = 1'b1;
      for (int k = 0; k < 9; k++) begin
         sample = tbl[k];
         wait_busy(1'b0, 1'b0, 4000, hit);
         check({15'h0000, hit}, {15'h0000, k < 8});
         if (hit) wait_busy(1'b0, 1'b1, 1700, hit);
      end
      start = 1'b0;
      res_ready = 1'b1;
      repeat (12) begin
         if (res_valid === 1'b1 && n < 8) begin
            check(res_data, tbl[n]);
            n++;
         end
         @(negedge i_clk_sys);
      end
      res_ready = 1'b0;
      check(n[15:0], 16'h0008);
      check({15'h0000, res_valid}, 16'h0000);
   endtask
   // Byte mode: the host reads upper then lower byte and rebuilds the word.
   task automatic t_byte_pair();
      logic hit;
      byte_mode = 1'b1;
      sample = 16'hC37E;
      start = 1'b1;
      wait_busy(1'b0, 1'b0, 4000, hit);
      start = 1'b0;
      wait_busy(1'b0, 1'b1, 1700, hit);
      res_ready = 1'b1;
      for (int i = 0; i < 200 && res_valid !== 1'b1; i++) @(negedge i_clk_sys);
      check(res_data, 16'hC37E);
      cycles(1);
      res_ready = 1'b0;
   endtask
   // Short pulse refused; select falling last starts; then a read after the end.
   task automatic t_start_read();
      logic hit;
      pins(1'b0, 1'b0, 1'b0);
      cycles(7);
      pins(1'b1, 1'b1, 1'b0);
      cycles(4);
      check({15'h0000, link_b.busy_n}, 16'h0001);
      sample_b = 16'h4B2D;
      pins(1'b1, 1'b0, 1'b0);
      cycles(2);
      pins(1'b0, 1'b0, 1'b0);
      #1 check(link_b.data_oe_n, 16'hFFFF);
      cycles(10);
      check({15'h0000, link_b.busy_n}, 16'h0000);
      check({14'h0000, conv_busy_b, sampling_b}, 16'h0002);
      pins(1'b1, 1'b1, 1'b0);
      sample_b = 16'h9E61;
      wait_busy(1'b1, 1'b1, 1700, hit);
      check(low_b[15:0], 16'h0640);
      check({14'h0000, conv_busy_b, sampling_b}, 16'h0001);
      pins(1'b0, 1'b1, 1'b0);
      cycles(2);
      check(link_b.data_oe_n, 16'h0000);
      check(link_b.data_out, 16'h4B2D);
   endtask
   // Select held low: the convert line alone starts, reads and is ignored while busy.
   task automatic t_ignore_restart();
      logic hit;
      pins(1'b0, 1'b0, 1'b0);
      #1 check(link_b.data_oe_n, 16'hFFFF);
      cycles(10);
      pins(1'b0, 1'b1, 1'b0);
      cycles(2);
      check({15'h0000, link_b.busy_n}, 16'h0000);
      check(link_b.data_out, 16'h4B2D);
      check(link_b.data_oe_n, 16'h0000);
      pins(1'b0, 1'b0, 1'b0);
      cycles(10);
      pins(1'b0, 1'b1, 1'b0);
      wait_busy(1'b1, 1'b1, 1700, hit);
      check(low_b[15:0], 16'h0640);
      check(link_b.data_out, 16'h9E61);
      cycles(2);
      check(link_b.data_out, 16'h9E61);
      byte_mode_b = 1'b1;
      cycles(2);
      check(link_b.data_out, 16'h009E);
      pins(1'b0, 1'b1, 1'b1);
      cycles(2);
      check(link_b.data_out, 16'h0061);
      pins(1'b1, 1'b1, 1'b1);
      #1 check(link_b.data_oe_n, 16'hFFFF);
      cycles(1);
      pins(1'b0, 1'b0, 1'b0);
      wait_busy(1'b1, 1'b0, 20, hit);
      wait_busy(1'b1, 1'b1, 1700, hit);
      cycles(2);
      check({15'h0000, link_b.busy_n}, 16'h0000);
      pins(1'b1, 1'b1, 1'b0);
      wait_busy(1'b1, 1'b1, 1700, hit);
   endtask
   task automatic results();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Main sequence: reset for eight cycles, then the scenarios in turn.
   initial begin
      pins(1'b1, 1'b1, 1'b0);
      cycles(8);
      i_rstn = 1'b1;
      t_fill_drain();
      t_byte_pair();
      t_start_read();
      t_ignore_restart();
      results();
   end
   // Watchdog well past the roughly 39000 cycles the scenarios need.
   initial begin
      #400us;
      fail_count++;
      results();
   end
endmodule
`default_nettype wire
